// File: inc/amr_consts.vh
`ifndef AMR_CONSTS_VH
`define AMR_CONSTS_VH
// register offsets
`define AMR_OFF_MUTE_DELAY   8'h51
`define AMR_OFF_LOOP_BW      8'h53
`define AMR_OFF_GAIN         8'h54
`define AMR_OFF_FILT_MARK    8'h5C
`define AMR_OFF_CONV         8'h5D
`define AMR_OFF_PIN_DIR      8'h60
`define AMR_OFF_PIN_FUNC     8'h61
// reset values
`define AMR_RST_MUTE_DELAY   8'h00
`define AMR_RST_LOOP_BW      8'h00
`define AMR_RST_GAIN         8'h00
`define AMR_RST_FILT_MARK    8'h00
`define AMR_RST_CONV         8'hF8
`define AMR_RST_PIN_DIR      8'h00
`define AMR_RST_PIN_FUNC     8'h00
// field positions
`define AMR_LEFT_DLY_HI      6
`define AMR_LEFT_DLY_LO      4
`define AMR_RIGHT_DLY_HI     2
`define AMR_RIGHT_DLY_LO     0
`define AMR_BW_HI            6
`define AMR_BW_LO            5
`define AMR_GAIN_HI          4
`define AMR_GAIN_LO          0
`define AMR_MARK_BIT         0
`define AMR_RATE_BIT         7
`define AMR_DITH_EN_HI       6
`define AMR_DITH_EN_LO       5
`define AMR_DITH_LVL_HI      4
`define AMR_DITH_LVL_LO      2
`define AMR_DEM_HI           1
`define AMR_DEM_LO           0
`define AMR_DIR_BIT          0
`define AMR_FUNC_HI          4
`define AMR_FUNC_LO          0
// pin function codes
`define AMR_FN_OFF           5'h00
`define AMR_FN_MUTE_BOTH     5'h03
`define AMR_FN_MUTE_LEFT     5'h04
`define AMR_FN_MUTE_RIGHT    5'h05
`define AMR_FN_CLK_BAD       5'h06
`define AMR_FN_FAULT         5'h0B
// mute delay, sample periods at 96 kHz
`define AMR_FS_REF_HZ        32'h00017700
`define AMR_DLY_0            20'h00450
`define AMR_DLY_1            20'h013E0
`define AMR_DLY_2            20'h027F0
`define AMR_DLY_3            20'h063F0
`define AMR_DLY_4            20'h0C8A0
`define AMR_DLY_5            20'h18F60
`define AMR_DLY_6            20'h3E760
`define AMR_DLY_7            20'h7CEC0
`endif

// File: verilog/amr_zero_timer.v
`timescale 1ns/10ps
`include "amr_consts.vh"
module amr_zero_timer (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       enable,
  input  wire       sample_stb,
  input  wire       sample_zero,
  input  wire [2:0] delay_code,
  output reg        muted_r
);
  reg  [19:0] run_r;
  reg  [19:0] limit;

  // delay code to sample count
  always @* begin
    case (delay_code)
      3'h0:    limit = `AMR_DLY_0;
      3'h1:    limit = `AMR_DLY_1;
      3'h2:    limit = `AMR_DLY_2;
      3'h3:    limit = `AMR_DLY_3;
      3'h4:    limit = `AMR_DLY_4;
      3'h5:    limit = `AMR_DLY_5;
      3'h6:    limit = `AMR_DLY_6;
      default: limit = `AMR_DLY_7;
    endcase
  end

  // RULE_03: counts sample periods
  always @(posedge sys_clk) begin
    if (rst || !enable) begin
      run_r   <= 20'h00000;
      muted_r <= 1'b0;
    end else if (sample_stb) begin
      if (!sample_zero) begin
        run_r   <= 20'h00000;
        muted_r <= 1'b0;
      end else begin
        // saturate the run, mute on the limit-th zero
        if (run_r < limit) begin
          run_r <= run_r + 20'h00001;
        end
        if (run_r >= limit - 20'h00001) begin
          muted_r <= 1'b1;
        end
      end
    end
  end
endmodule // amr_zero_timer

// File: verilog/amr_pin_sync.v
`timescale 1ns/10ps
module amr_pin_sync (
  input  wire sys_clk,
  input  wire rst,
  input  wire pin_in,
  output reg  level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // three stages, accept when last two agree
  always @(posedge sys_clk) begin
    if (rst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule // amr_pin_sync

// File: verilog/amr_regs.v
// What this block does
// RULE_01: bits 6..4 of the mute delay register pick the left zero-run time, 11.5 ms up to 5.33 s.
// RULE_02: bits 2..0 of the same register pick the right zero-run time from the eight listed codes.
// RULE_03: zero-run times are counted in sample periods, so they scale with the sample rate.
// RULE_04: bits 6..5 of the loop bandwidth register select 80, 100, 120 or 175 kHz, reset 00.
// RULE_05: the host should pick 175 kHz at 768 kHz switching and at most 120 kHz at 384 kHz.
// RULE_06: the five-bit gain field attenuates 0.5 dB per code from 0 dB down to -15.5 dB.
// RULE_07: the host sets bit 0 of the marker register before the first coefficient of a biquad.
// RULE_08: converter bit 7 picks the modulator rate, 0 for 6.144 MHz and 1 for 3.072 MHz, reset 1.
// RULE_09: converter bits 6..5 enable none, main, second or both dither stages, reset 11.
// RULE_10: converter bits 4..2 pick the dither amplitude, code 100 largest to 011 smallest, reset 110.
// RULE_11: converter bits 1..0 enable element matching at 00 and disable it at 11, reset 00.
// RULE_12: bit 0 of the pin direction register makes the multi pin an input at 0 and an output at 1.
// RULE_13: as an output, the pin drives the signal chosen by the five-bit pin function selector.
// RULE_14: every bit of every register reads back the last value written, or its reset value.
`timescale 1ns/10ps
`include "amr_consts.vh"
module amr_regs (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_r,
  output reg        reg_ack_r,
  input  wire       sample_stb,
  input  wire       left_zero,
  input  wire       right_zero,
  input  wire       left_mute_en,
  input  wire       right_mute_en,
  input  wire       mute_joint,
  input  wire       clk_invalid,
  input  wire       fault_n,
  input  wire       multi_pin_in,
  output wire       multi_pin_out,
  output wire       multi_pin_oe,
  output wire       multi_pin_level,
  output wire       left_muted,
  output wire       right_muted,
  output wire [1:0] loop_bandwidth_sel,
  output wire [4:0] analog_attenuation,
  output wire       first_coef_marker,
  output wire       dac_rate_slow,
  output wire       dither_main_en,
  output wire       dither_second_en,
  output wire [2:0] dither_level,
  output wire [1:0] element_matching_sel,
  output wire       dynamic_element_matching_en
);
  reg  [7:0] mute_delay_r;
  reg  [7:0] loop_bw_r;
  reg  [7:0] gain_r;
  reg  [7:0] filt_mark_r;
  reg  [7:0] conv_r;
  reg  [7:0] pin_dir_r;
  reg  [7:0] pin_func_r;
  reg  [7:0] rdata_nxt;
  reg        pin_drive_r;
  wire       left_run;
  wire       right_run;
  wire       both_run;
  wire       pin_sync;

  // RULE_14: full-width stores keep reserved bits
  always @(posedge sys_clk) begin
    if (rst) begin
      mute_delay_r <= `AMR_RST_MUTE_DELAY;
      loop_bw_r    <= `AMR_RST_LOOP_BW;
      gain_r       <= `AMR_RST_GAIN;
      filt_mark_r  <= `AMR_RST_FILT_MARK;
      conv_r       <= `AMR_RST_CONV;
      pin_dir_r    <= `AMR_RST_PIN_DIR;
      pin_func_r   <= `AMR_RST_PIN_FUNC;
    end else if (reg_wr) begin
      case (reg_addr)
        `AMR_OFF_MUTE_DELAY: mute_delay_r <= reg_wdata;
        `AMR_OFF_LOOP_BW:    loop_bw_r    <= reg_wdata;
        `AMR_OFF_GAIN:       gain_r       <= reg_wdata;
        `AMR_OFF_FILT_MARK:  filt_mark_r  <= reg_wdata;
        `AMR_OFF_CONV:       conv_r       <= reg_wdata;
        `AMR_OFF_PIN_DIR:    pin_dir_r    <= reg_wdata;
        `AMR_OFF_PIN_FUNC:   pin_func_r   <= reg_wdata;
        default:             pin_func_r   <= pin_func_r;
      endcase
    end
  end

  // RULE_14: read mux, unmapped reads zero
  always @* begin
    case (reg_addr)
      `AMR_OFF_MUTE_DELAY: rdata_nxt = mute_delay_r;
      `AMR_OFF_LOOP_BW:    rdata_nxt = loop_bw_r;
      `AMR_OFF_GAIN:       rdata_nxt = gain_r;
      `AMR_OFF_FILT_MARK:  rdata_nxt = filt_mark_r;
      `AMR_OFF_CONV:       rdata_nxt = conv_r;
      `AMR_OFF_PIN_DIR:    rdata_nxt = pin_dir_r;
      `AMR_OFF_PIN_FUNC:   rdata_nxt = pin_func_r;
      default:             rdata_nxt = 8'h00;
    endcase
  end

  // registered read data and access ack
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
      reg_ack_r   <= 1'b0;
    end else begin
      reg_ack_r <= reg_wr | reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end
    end
  end

  // RULE_01: left zero-run timer
  amr_zero_timer u_left (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .enable      (left_mute_en),
    .sample_stb  (sample_stb),
    .sample_zero (left_zero),
    .delay_code  (mute_delay_r[`AMR_LEFT_DLY_HI:`AMR_LEFT_DLY_LO]),
    .muted_r     (left_run)
  );

  // RULE_02: right zero-run timer
  amr_zero_timer u_right (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .enable      (right_mute_en),
    .sample_stb  (sample_stb),
    .sample_zero (right_zero),
    .delay_code  (mute_delay_r[`AMR_RIGHT_DLY_HI:`AMR_RIGHT_DLY_LO]),
    .muted_r     (right_run)
  );

  // joint mode mutes only when both channels qualify
  assign both_run    = left_run & right_run;
  assign left_muted  = mute_joint ? both_run : left_run;
  assign right_muted = mute_joint ? both_run : right_run;

  // RULE_04: loop bandwidth code
  assign loop_bandwidth_sel = loop_bw_r[`AMR_BW_HI:`AMR_BW_LO];
  // RULE_06: attenuation code, 0.5 dB per step
  assign analog_attenuation = gain_r[`AMR_GAIN_HI:`AMR_GAIN_LO];
  // first-coefficient marker to the coefficient path
  assign first_coef_marker = filt_mark_r[`AMR_MARK_BIT];
  // RULE_08: modulator rate select
  assign dac_rate_slow = conv_r[`AMR_RATE_BIT];
  // RULE_09: dither stage enables
  assign dither_main_en   = conv_r[`AMR_DITH_EN_LO];
  assign dither_second_en = conv_r[`AMR_DITH_EN_HI];
  // RULE_10: dither amplitude code
  assign dither_level = conv_r[`AMR_DITH_LVL_HI:`AMR_DITH_LVL_LO];
  // RULE_11: element matching on only at 00
  assign element_matching_sel        = conv_r[`AMR_DEM_HI:`AMR_DEM_LO];
  assign dynamic_element_matching_en = (conv_r[`AMR_DEM_HI:`AMR_DEM_LO] == 2'h0);

  // RULE_13: pin function select
  always @(posedge sys_clk) begin
    if (rst) begin
      pin_drive_r <= 1'b0;
    end else begin
      case (pin_func_r[`AMR_FUNC_HI:`AMR_FUNC_LO])
        `AMR_FN_MUTE_BOTH:  pin_drive_r <= left_muted & right_muted;
        `AMR_FN_MUTE_LEFT:  pin_drive_r <= left_muted;
        `AMR_FN_MUTE_RIGHT: pin_drive_r <= right_muted;
        `AMR_FN_CLK_BAD:    pin_drive_r <= clk_invalid;
        `AMR_FN_FAULT:      pin_drive_r <= fault_n;
        default:            pin_drive_r <= 1'b0;
      endcase
    end
  end

  // RULE_12: direction bit enables the driver
  assign multi_pin_oe  = pin_dir_r[`AMR_DIR_BIT];
  assign multi_pin_out = pin_drive_r;

  // input level when the pin is not driven
  amr_pin_sync u_pin (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (multi_pin_in),
    .level_r (pin_sync)
  );
  assign multi_pin_level = pin_sync;
endmodule // amr_regs

// File: verif/amr_host.sv
`timescale 1ns/10ps
module amr_host (
  input  wire       sys_clk,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata_r,
  input  wire       reg_ack_r
);
  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one-cycle strobe, lines flipped once released
  task wr(input [7:0] a, input [7:0] d); begin
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  end endtask
  // read, answer taken while ack stands
  task rd(input [7:0] a, output [7:0] d, output k); begin
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_r;
    k = reg_ack_r;
  end endtask
  function [1:0] bw_for(input fast); begin
    bw_for = fast ? 2'b11 : 2'b10;
  end endfunction
  task coef_start; begin
    wr(8'h5C, 8'h01);
  end endtask
endmodule // amr_host

// File: verif/amr_regs_monitor.sv
`timescale 1ns/10ps
module amr_regs_monitor (
  input wire       sys_clk,
  input wire       rst,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_r,
  input wire       reg_ack_r,
  input wire       sample_stb,
  input wire       left_zero,
  input wire       left_mute_en,
  input wire       left_muted,
  input wire       multi_pin_oe,
  input wire [1:0] loop_bandwidth_sel,
  input wire [4:0] analog_attenuation,
  input wire       dac_rate_slow,
  input wire       dither_main_en,
  input wire       dither_second_en,
  input wire [1:0] element_matching_sel,
  input wire       dynamic_element_matching_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // bus answer
  AST_ACK: assert property ((reg_wr || reg_rd) |=> reg_ack_r) else $error("ack missing");
  AST_NOACK: assert property (!(reg_wr || reg_rd) |=> !reg_ack_r) else $error("stray ack");
  AST_RDATA: assert property (!reg_rd |=> $stable(reg_rdata_r)) else $error("rdata moved");
  // field outputs follow writes
  AST_BW: assert property (reg_wr && reg_addr == 8'h53 |=>
    loop_bandwidth_sel == $past(reg_wdata[6:5])) else $error("bandwidth wrong");
  AST_GAIN: assert property (reg_wr && reg_addr == 8'h54 |=>
    analog_attenuation == $past(reg_wdata[4:0])) else $error("gain wrong");
  AST_CONV: assert property (reg_wr && reg_addr == 8'h5D |=> dac_rate_slow == $past(reg_wdata[7])
    && dither_second_en == $past(reg_wdata[6]) && dither_main_en == $past(reg_wdata[5])) else $error("conv wrong");
  AST_DEM: assert property (reg_wr && reg_addr == 8'h5D |=>
    dynamic_element_matching_en == ($past(reg_wdata[1:0]) == 2'b00)) else $error("dem wrong");
  AST_OE: assert property (reg_wr && reg_addr == 8'h60 |=> multi_pin_oe == $past(reg_wdata[0]))
    else $error("oe wrong");
  // zero run broken clears mute
  AST_MCLR: assert property ((sample_stb && !left_zero) || !left_mute_en |=> !left_muted)
    else $error("mute not cleared");
  CV_WR: cover property (reg_wr && reg_addr == 8'h5D);
  CV_MUTE: cover property ($rose(left_muted));
  CV_OE: cover property ($rose(multi_pin_oe));
endmodule // amr_regs_monitor
bind amr_regs amr_regs_monitor i_amr_regs_monitor (.*);

// File: verif/amr_regs_test.sv
`timescale 1ns/10ps
`define AMR_CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module amr_regs_test;
  reg        sys_clk = 1'b0, rst = 1'b1, sample_stb = 1'b0, left_zero = 1'b0, right_zero = 1'b0;
  reg        left_mute_en = 1'b0, right_mute_en = 1'b0, mute_joint = 1'b0, clk_invalid = 1'b0;
  reg        fault_n = 1'b1, multi_pin_in = 1'b0, k;
  wire       reg_wr, reg_rd, reg_ack_r, multi_pin_out, multi_pin_oe, multi_pin_level, left_muted;
  wire       right_muted, first_coef_marker, dac_rate_slow, dither_main_en, dither_second_en;
  wire       dynamic_element_matching_en;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_r;
  wire [1:0] loop_bandwidth_sel, element_matching_sel;
  wire [4:0] analog_attenuation;
  wire [2:0] dither_level;
  reg  [7:0] d;
  reg [31:0] rows [0:7];
  integer    n_mismatch = 0, cmp_count = 0, cyc = 0, i;
  amr_regs i_amr_regs (.*);
  amr_host i_amr_host (.*);
  // clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      conclude;
    end
  end
  task conclude; begin
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end endtask
  // sample strobes, every other cycle
  task stb(input integer n); integer j; begin
    for (j = 0; j < n; j++) begin
      @(negedge sys_clk);
      sample_stb = 1'b1;
      @(negedge sys_clk);
      sample_stb = 1'b0;
    end
  end endtask
  initial begin
    // rows: address, write data, readback, reset value
    rows[0] = 32'h51A5A500; rows[1] = 32'h53FFFF00; rows[2] = 32'h541F1F00; rows[3] = 32'h5C818100;
    rows[4] = 32'h5D0000F8; rows[5] = 32'h60FFFF00; rows[6] = 32'h611F1F00; rows[7] = 32'h52FF0000;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    for (i = 0; i < 8; i++) begin
      i_amr_host.rd(rows[i][31:24], d, k);
      `AMR_CHK("reset value", rows[i][7:0], d)
      i_amr_host.wr(rows[i][31:24], rows[i][23:16]);
      i_amr_host.rd(rows[i][31:24], d, k);
      `AMR_CHK("readback", rows[i][15:8], d)
      `AMR_CHK("read ack", 1'b1, k)
    end
    `AMR_CHK("gain", 5'h1F, analog_attenuation)
    `AMR_CHK("oe set", 1'b1, multi_pin_oe)
    $display("table test done");
    for (i = 0; i < 4; i++) begin
      i_amr_host.wr(8'h53, {1'b0, i[1:0], 5'h00});
      `AMR_CHK("bandwidth", i[1:0], loop_bandwidth_sel)
      i_amr_host.wr(8'h5D, {1'b1, i[1:0], 5'h18});
      `AMR_CHK("dither main", i[0], dither_main_en)
      `AMR_CHK("dither second", i[1], dither_second_en)
      `AMR_CHK("dither level", 3'b110, dither_level)
      `AMR_CHK("rate", 1'b1, dac_rate_slow)
    end
    i_amr_host.wr(8'h53, {1'b0, i_amr_host.bw_for(1'b1), 5'h00});
    `AMR_CHK("fast bandwidth", 2'b11, loop_bandwidth_sel)
    i_amr_host.wr(8'h5D, 8'h03);
    `AMR_CHK("dem off", 1'b0, dynamic_element_matching_en)
    `AMR_CHK("rate fast", 1'b0, dac_rate_slow)
    `AMR_CHK("dem field", 2'h3, element_matching_sel)
    `AMR_CHK("dither zero", 3'h0, dither_level)
    i_amr_host.wr(8'h5C, 8'h00);
    `AMR_CHK("marker clear", 1'b0, first_coef_marker)
    i_amr_host.coef_start;
    `AMR_CHK("marker", 1'b1, first_coef_marker)
    $display("field test done");
    // left 1104 samples, right 5088 samples, pin shows left mute
    i_amr_host.wr(8'h51, 8'h01);
    i_amr_host.wr(8'h61, 8'h04);
    {left_zero, right_zero, left_mute_en, right_mute_en} = 4'hF;
    stb(1103);
    `AMR_CHK("left early", 1'b0, left_muted)
    stb(1);
    `AMR_CHK("left muted", 1'b1, left_muted)
    `AMR_CHK("right early", 1'b0, right_muted)
    @(negedge sys_clk);
    `AMR_CHK("pin mute flag", 1'b1, multi_pin_out)
    stb(3983);
    `AMR_CHK("right not yet", 1'b0, right_muted)
    stb(1);
    `AMR_CHK("right muted", 1'b1, right_muted)
    left_zero = 1'b0;
    stb(1);
    `AMR_CHK("left cleared", 1'b0, left_muted)
    mute_joint = 1'b1;
    @(negedge sys_clk);
    `AMR_CHK("joint gate", 1'b0, right_muted)
    mute_joint = 1'b0;
    i_amr_host.wr(8'h61, 8'h05);
    repeat (2) @(negedge sys_clk);
    `AMR_CHK("pin right flag", 1'b1, multi_pin_out)
    i_amr_host.wr(8'h61, 8'h03);
    repeat (2) @(negedge sys_clk);
    `AMR_CHK("pin both flag", 1'b0, multi_pin_out)
    clk_invalid = 1'b1;
    i_amr_host.wr(8'h61, 8'h06);
    repeat (2) @(negedge sys_clk);
    `AMR_CHK("pin clock flag", 1'b1, multi_pin_out)
    clk_invalid = 1'b0;
    i_amr_host.wr(8'h61, 8'h0B);
    repeat (2) @(negedge sys_clk);
    `AMR_CHK("fault high", 1'b1, multi_pin_out)
    fault_n = 1'b0;
    multi_pin_in = 1'b1;
    repeat (6) @(negedge sys_clk);
    `AMR_CHK("fault low", 1'b0, multi_pin_out)
    `AMR_CHK("pin level", 1'b1, multi_pin_level)
    fault_n = 1'b1;
    $display("mute and pin test done");
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    `AMR_CHK("oe reset", 1'b0, multi_pin_oe)
    i_amr_host.rd(8'h5D, d, k);
    `AMR_CHK("conv reset", 8'hF8, d)
    i_amr_host.rd(8'h53, d, k);
    `AMR_CHK("bandwidth reset", 8'h00, d)
    $display("reset test done");
    conclude;
  end
endmodule // amr_regs_test
